// [design/mch_pkg.sv]
package mch_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CR = 8'h00;
    localparam logic [7:0] OFS_MR = 8'h04;
    localparam logic [7:0] OFS_DTOR = 8'h08;
    localparam logic [7:0] OFS_SDCR = 8'h0c;
    localparam logic [7:0] OFS_ARGR = 8'h10;
    localparam logic [7:0] OFS_CMDR = 8'h14;
    localparam logic [7:0] OFS_BLKR = 8'h18;
    localparam logic [7:0] OFS_SR = 8'h40;
    // field positions
    localparam int CR_SWRST = 7;
    localparam int MR_DMA_MODE = 15;
    localparam int MR_FBYTE = 13;
    localparam int BLOCK_LENGTH_LSB = 16;
    localparam int SDCR_BUS = 7;
    localparam int CMD_RSP_LSB = 6;
    localparam int CMD_SPC_LSB = 8;
    localparam int CMD_OD = 11;
    localparam int CMD_LAT = 12;
    localparam int CMD_TRC_LSB = 16;
    localparam int CMD_DIR = 18;
    localparam int CMD_TYP_LSB = 19;
    localparam int CMD_IOS_LSB = 24;
    localparam int SR_COMMAND_READY_FLAG = 0;
    localparam int SR_DATA_TIMEOUT_ERROR = 22;
    localparam int SR_OVERRUN_FLAG = 30;
    localparam int SR_UNDERRUN_FLAG = 31;
    // reset values and counts
    localparam logic [31:0] REG_RESET = 32'h0;
    localparam logic [6:0] INIT_CLOCKS = 7'h4a;
    localparam logic [6:0] LAT_SHORT = 7'h05;
    localparam logic [6:0] LAT_LONG = 7'h40;
    // command codes
    localparam logic [2:0] SPC_INIT = 3'h1;
    localparam logic [2:0] SPC_SYNC = 3'h2;
    localparam logic [2:0] SPC_RSVD = 3'h3;
    localparam logic [2:0] SPC_INT_CMD = 3'h4;
    localparam logic [2:0] SPC_INT_RESP = 3'h5;
    localparam logic [1:0] RSP_48 = 2'h1;
    localparam logic [1:0] RSP_136 = 2'h2;
    localparam logic [1:0] TRC_START = 2'h1;
    localparam logic [1:0] TRC_STOP = 2'h2;
    localparam logic [1:0] IOS_SUSPEND = 2'h1;
    localparam logic [1:0] IOS_RESUME = 2'h2;
    localparam logic [2:0] TYP_MULTI = 3'h1;
    localparam logic [2:0] TYP_SDIO_BYTE = 3'h4;

    typedef struct packed {
        logic [5:0] index;
        logic [31:0] arg;
        logic [2:0] special_command;
        logic resp_present;
        logic resp_long;
        logic open_drain;
        logic xfer_start;
        logic xfer_stop;
        logic read_dir;
        logic [2:0] transfer_type;
        logic sdio_suspend;
        logic sdio_resume;
    } mch_cmd_type;

    typedef struct packed {
        logic [15:0] blk_count;
        logic [15:0] blk_len;
        logic unbounded;
        logic wide_bus;
        logic [1:0] slot;
    } mch_xfer_type;

    // timeout multiplier per 3-bit code
    function automatic logic [20:0] dto_mult(input logic [2:0] code);
        unique case (code)
            3'h0: dto_mult = 21'h000001;
            3'h1: dto_mult = 21'h000010;
            3'h2: dto_mult = 21'h000080;
            3'h3: dto_mult = 21'h000100;
            3'h4: dto_mult = 21'h000400;
            3'h5: dto_mult = 21'h001000;
            3'h6: dto_mult = 21'h010000;
            3'h7: dto_mult = 21'h100000;
        endcase
    endfunction
endpackage

// [design/mch_setup.sv]
// The APB register port and the address map were left to the implementer.
module mch_setup
    import mch_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic card_clk,
    input wire logic cmd_bit,
    input wire logic cmd_drive,
    input wire logic cmd_sent,
    input wire logic block_done,
    input wire logic data_wait,
    input wire logic underrun_evt,
    input wire logic overrun_evt,
    input wire logic dma_done,
    output mch_cmd_type cmd_desc,
    output logic cmd_start,
    output logic init_active,
    output logic [6:0] resp_latency,
    output mch_xfer_type xfer,
    output logic dma_enable,
    output logic dma_force_byte,
    output logic cmd_line_o,
    output logic cmd_line_oe
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_INIT, ST_SYNC, ST_ISSUE, ST_BUSY
    } mch_state_type;

    mch_state_type state_r, state_nxt;
    logic dma_mode_r, fbyte_r, bus_r, cmd_ready_r, intr_wait_r;
    logic data_timeout_error_r, underrun_flag_r, overrun_flag_r, to_expired, card_rise;
    logic [1:0] slot_r;
    logic [6:0] dto_r, init_cnt_r;
    logic [15:0] blk_len_r, blk_cnt_r;
    logic [31:0] arg_r, cmdr_r, rd_mr, rd_sr, rd_word;

    // apb phase and address decode
    wire setup = psel & ~penable;
    wire access = psel & penable & pready;
    wire wr = access & pwrite;
    wire rd = access & ~pwrite;
    wire sel_cr = paddr == OFS_CR;
    wire sel_mr = paddr == OFS_MR;
    wire sel_dtor = paddr == OFS_DTOR;
    wire sel_sdcr = paddr == OFS_SDCR;
    wire sel_argr = paddr == OFS_ARGR;
    wire sel_cmdr = paddr == OFS_CMDR;
    wire sel_blkr = paddr == OFS_BLKR;
    wire sel_sr = paddr == OFS_SR;
    wire mapped = sel_cr | sel_mr | sel_dtor | sel_sdcr | sel_argr
        | sel_cmdr | sel_blkr | sel_sr;
    wire swrst = wr & sel_cr & pwdata[CR_SWRST];

    // command write acceptance; reserved codes are refused as well
    wire [2:0] wr_spc = pwdata[CMD_SPC_LSB +: 3];
    wire wr_rsvd = (pwdata[CMD_RSP_LSB +: 2] == 2'h3)
        | (wr_spc == SPC_RSVD) | (wr_spc > SPC_INT_RESP)
        | (pwdata[CMD_TRC_LSB +: 2] == 2'h3)
        | (pwdata[CMD_IOS_LSB +: 2] == 2'h3)
        | (pwdata[CMD_TYP_LSB +: 3] == 3'h3)
        | (pwdata[CMD_TYP_LSB +: 3] > 3'h5);
    wire cmd_ok = intr_wait_r ? (wr_spc == SPC_INT_RESP)
        : cmd_ready_r;
    wire cmd_take = wr & sel_cmdr & cmd_ok & ~wr_rsvd & ~swrst;
    wire [2:0] cur_spc = cmdr_r[CMD_SPC_LSB +: 3];
    wire [2:0] cur_typ = cmdr_r[CMD_TYP_LSB +: 3];
    wire sent_now = (state_r == ST_BUSY) & cmd_sent;

    // command sequencing
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (cmd_take) begin
                    if (wr_spc == SPC_INIT)
                        state_nxt = ST_INIT;
                    else if (wr_spc == SPC_SYNC)
                        state_nxt = ST_SYNC;
                    else
                        state_nxt = ST_ISSUE;
                end
            end
            ST_INIT: begin
                if (init_cnt_r == INIT_CLOCKS)
                    state_nxt = ST_ISSUE;
            end
            ST_SYNC: begin
                if (block_done)
                    state_nxt = ST_ISSUE;
            end
            ST_ISSUE: state_nxt = ST_BUSY;
            ST_BUSY: begin
                if (cmd_sent)
                    state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            state_r <= ST_IDLE;
        else if (swrst)
            state_r <= ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // card clock rising edges counted only while initialising
    mch_sync u_clk_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(card_clk),
        .rise(card_rise)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            init_cnt_r <= '0;
        else if (state_r != ST_INIT)
            init_cnt_r <= '0;
        else if (card_rise && init_cnt_r != INIT_CLOCKS)
            init_cnt_r <= init_cnt_r + 7'h1;
    end

    // command ready and interrupt-mode hold
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_ready_r <= 1'b1;
            intr_wait_r <= 1'b0;
        end else if (swrst) begin
            cmd_ready_r <= 1'b1;
            intr_wait_r <= 1'b0;
        end else if (cmd_take) begin
            cmd_ready_r <= 1'b0;
        end else if (sent_now) begin
            // interrupt command keeps the register locked to a response
            cmd_ready_r <= cur_spc != SPC_INT_CMD;
            intr_wait_r <= cur_spc == SPC_INT_CMD;
        end
    end

    // software-written configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {dma_mode_r, fbyte_r, bus_r, slot_r} <= 5'h0;
            {blk_len_r, blk_cnt_r} <= REG_RESET;
            dto_r <= REG_RESET[6:0];
            {arg_r, cmdr_r} <= {REG_RESET, REG_RESET};
        end else if (swrst) begin
            {dma_mode_r, fbyte_r, bus_r, slot_r} <= 5'h0;
            {blk_len_r, blk_cnt_r} <= REG_RESET;
            dto_r <= REG_RESET[6:0];
            {arg_r, cmdr_r} <= {REG_RESET, REG_RESET};
        end else begin
            if (wr && sel_mr) begin
                dma_mode_r <= pwdata[MR_DMA_MODE];
                fbyte_r <= pwdata[MR_FBYTE];
                blk_len_r <= pwdata[BLOCK_LENGTH_LSB +: 16];
            end
            if (wr && sel_blkr) begin
                blk_len_r <= pwdata[BLOCK_LENGTH_LSB +: 16];
                blk_cnt_r <= pwdata[15:0];
            end
            if (wr && sel_dtor)
                dto_r <= pwdata[6:0];
            if (wr && sel_sdcr) begin
                bus_r <= pwdata[SDCR_BUS];
                slot_r <= pwdata[1:0];
            end
            if (wr && sel_argr)
                arg_r <= pwdata;
            if (cmd_take)
                cmdr_r <= pwdata;
        end
    end

    // data timeout between blocks
    mch_timeout u_timeout (
        .pclk(pclk),
        .presetn(presetn),
        .run(data_wait & ~swrst),
        .cyc(dto_r[3:0]),
        .mul(dto_r[6:4]),
        .expired(to_expired)
    );

    // sticky status; a setting event wins over the clear
    wire sr_rd = rd & sel_sr;
    wire dma_clr = dma_mode_r & dma_done;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {data_timeout_error_r, underrun_flag_r, overrun_flag_r} <= 3'h0;
        end else if (swrst) begin
            {data_timeout_error_r, underrun_flag_r, overrun_flag_r} <= 3'h0;
        end else begin
            data_timeout_error_r <= to_expired | (data_timeout_error_r & ~sr_rd);
            underrun_flag_r <= underrun_evt | (underrun_flag_r & ~dma_clr);
            overrun_flag_r <= overrun_evt | (overrun_flag_r & ~dma_clr);
        end
    end

    // read word assembly
    always_comb begin
        rd_mr = '0;
        rd_mr[BLOCK_LENGTH_LSB +: 16] = blk_len_r;
        rd_mr[MR_DMA_MODE] = dma_mode_r;
        rd_mr[MR_FBYTE] = fbyte_r;
        rd_sr = '0;
        rd_sr[SR_COMMAND_READY_FLAG] = cmd_ready_r;
        rd_sr[SR_DATA_TIMEOUT_ERROR] = data_timeout_error_r;
        rd_sr[SR_OVERRUN_FLAG] = overrun_flag_r;
        rd_sr[SR_UNDERRUN_FLAG] = underrun_flag_r;
    end

    assign rd_word = sel_mr ? rd_mr
        : sel_dtor ? {25'h0, dto_r}
        : sel_sdcr ? {24'h0, bus_r, 5'h0, slot_r}
        : sel_argr ? arg_r
        : sel_blkr ? {blk_len_r, blk_cnt_r}
        : sel_sr ? rd_sr : 32'h0;

    // apb answer registered in setup, so access ends in one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= setup;
            pslverr <= setup & ~mapped;
            prdata <= (setup && !pwrite) ? rd_word : 32'h0;
        end
    end

    // command descriptor handed to the shifter on issue
    wire [1:0] cur_rsp = cmdr_r[CMD_RSP_LSB +: 2];
    wire [1:0] cur_trc = cmdr_r[CMD_TRC_LSB +: 2];
    wire [1:0] cur_ios = cmdr_r[CMD_IOS_LSB +: 2];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_desc <= '0;
            cmd_start <= 1'b0;
            init_active <= 1'b0;
        end else begin
            cmd_start <= state_r == ST_ISSUE;
            init_active <= state_nxt == ST_INIT;
            if (state_r == ST_ISSUE) begin
                cmd_desc.index <= cmdr_r[5:0];
                cmd_desc.arg <= arg_r;
                cmd_desc.special_command <= cur_spc;
                cmd_desc.resp_present <= cur_rsp != 2'h0;
                cmd_desc.resp_long <= cur_rsp == RSP_136;
                cmd_desc.open_drain <= cmdr_r[CMD_OD];
                cmd_desc.xfer_start <= cur_trc == TRC_START;
                cmd_desc.xfer_stop <= cur_trc == TRC_STOP;
                cmd_desc.read_dir <= cmdr_r[CMD_DIR];
                cmd_desc.transfer_type <= cur_typ;
                cmd_desc.sdio_suspend <= cur_ios == IOS_SUSPEND;
                cmd_desc.sdio_resume <= cur_ios == IOS_RESUME;
            end
        end
    end

    // transfer setup, latency limit and command line drive
    wire byte_mode = cur_typ == TYP_SDIO_BYTE;
    wire od = cmd_desc.open_drain;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xfer <= '0;
            resp_latency <= LAT_SHORT;
            dma_enable <= 1'b0;
            dma_force_byte <= 1'b0;
            cmd_line_o <= 1'b1;
            cmd_line_oe <= 1'b0;
        end else begin
            xfer.blk_count <= blk_cnt_r;
            xfer.blk_len <= byte_mode ? 16'h0 : blk_len_r;
            xfer.unbounded <= (cur_typ == TYP_MULTI)
                & (blk_cnt_r == 16'h0);
            xfer.wide_bus <= bus_r;
            xfer.slot <= slot_r;
            resp_latency <= cmdr_r[CMD_LAT] ? LAT_LONG
                : LAT_SHORT;
            dma_enable <= dma_mode_r;
            dma_force_byte <= fbyte_r;
            // open drain only ever pulls low, released line floats high
            cmd_line_o <= od ? 1'b0 : cmd_bit;
            cmd_line_oe <= cmd_drive & (~od | ~cmd_bit);
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ready_clear: assert property (cmd_take |=> !cmd_ready_r)
        else $error("command ready not cleared by write");
    a_busy_ignore: assert property (wr && sel_cmdr && !cmd_ready_r
        && !intr_wait_r |=> $stable(cmdr_r))
        else $error("command register changed while busy");
    a_intr_only: assert property (intr_wait_r && wr && sel_cmdr
        && wr_spc != SPC_INT_RESP |=> $stable(cmdr_r))
        else $error("non-response write taken after interrupt cmd");
    a_init_count: assert property (state_r == ST_INIT
        && state_nxt == ST_ISSUE |-> init_cnt_r == 7'h4a)
        else $error("init issued without 74 card clocks");
    a_sync_hold: assert property (state_r == ST_SYNC && !block_done
        |=> !cmd_start ##1 state_r != ST_BUSY)
        else $error("synchronised command sent before block end");
    a_arg_whole: assert property (cmd_start
        |-> cmd_desc.arg == $past(arg_r))
        else $error("argument differs from register");
    a_byte_len: assert property ($past(byte_mode)
        |-> xfer.blk_len == 16'h0)
        else $error("block length used in sdio byte mode");
    a_data_timeout_error_set: assert property (to_expired |=> data_timeout_error_r)
        else $error("timeout did not raise error flag");
    a_dma_clear: assert property (dma_clr && !underrun_evt
        |=> !underrun_flag_r)
        else $error("underrun kept after dma completion");
    a_od_low: assert property (cmd_line_oe && $past(od)
        |-> !cmd_line_o)
        else $error("open drain line driven high");
    a_latency: assert property ($past(cmdr_r[CMD_LAT]) |-> resp_latency
        == 7'h40)
        else $error("long latency not selected");
    a_ready_set: assert property (sent_now && cur_spc != SPC_INT_CMD
        |=> cmd_ready_r)
        else $error("command ready not set after send");

    c_init_cmd: cover property (state_r == ST_INIT ##1 state_r == ST_ISSUE);
    c_sync_cmd: cover property (state_r == ST_SYNC ##1 state_r == ST_ISSUE);
    c_intr_pair: cover property (intr_wait_r ##[1:50] cmd_take);
    c_timeout: cover property (to_expired);
endmodule

// [design/mch_sync.sv]
module mch_sync
    import mch_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic async_in,
    output logic rise
);
    logic s1_r, s2_r, s3_r;

    // two stages, then a third for edge finding off the second only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            rise <= 1'b0;
        end else begin
            s1_r <= async_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            rise <= s2_r & ~s3_r;
        end
    end
endmodule

// [design/mch_timeout.sv]
module mch_timeout
    import mch_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [3:0] cyc,
    input wire logic [2:0] mul,
    output logic expired
);
    logic [20:0] pre_r;
    logic [3:0] cnt_r;
    logic done_r;

    // prescaler wraps every multiplier cycles, count of wraps vs cycles
    wire [20:0] limit = dto_mult(mul) - 21'h1;
    wire tick = pre_r == limit;
    wire hit = run & ~done_r & (cnt_r == cyc);

    // one pulse per wait; a stopped wait restarts from zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_r <= '0;
            cnt_r <= '0;
            done_r <= 1'b0;
            expired <= 1'b0;
        end else if (!run) begin
            pre_r <= '0;
            cnt_r <= '0;
            done_r <= 1'b0;
            expired <= 1'b0;
        end else begin
            pre_r <= tick ? 21'h0 : pre_r + 21'h1;
            if (tick && cnt_r != cyc)
                cnt_r <= cnt_r + 4'h1;
            done_r <= done_r | hit;
            expired <= hit;
        end
    end
endmodule

// [tb/mch_card_model.sv]
module mch_card_model (
    input wire logic pclk,
    input wire logic init_active,
    input wire logic cmd_start,
    input wire logic slow,
    output logic card_clk,
    output logic cmd_sent
);
    timeunit 1ns;
    timeprecision 100ps;
    // card clock runs only during init, odd phase to the bus clock
    initial begin
        card_clk = 1'b0;
        #37;
        forever #100 card_clk = init_active ? ~card_clk : 1'b0;
    end
    // slow answers leave room to poke a busy command register
    initial begin
        cmd_sent = 1'b0;
        forever begin
            @(posedge pclk);
            if (cmd_start === 1'b1) begin
                repeat (slow ? 40 : 2) @(posedge pclk);
                cmd_sent <= 1'b1;
                @(posedge pclk);
                cmd_sent <= 1'b0;
            end
        end
    end
endmodule

// [tb/mch_setup_tb.sv]
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
    $display("unexpected at %0t got %h want %h", $time, a, b); end end
module mch_setup_tb
    import mch_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, ok;
    logic slow, cmd_bit, cmd_drive, block_done, data_wait, dma_done;
    logic underrun_evt, overrun_evt, card_clk, cmd_sent, cmd_start;
    logic init_active, dma_enable, dma_force_byte, cmd_line_o, cmd_line_oe;
    logic [1:0] line_exp;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed, c, a, b;
    logic [6:0] resp_latency;
    logic [2:0] typs [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5};
    mch_cmd_type cmd_desc;
    mch_xfer_type xfer;
    int miscompares, n_tests, nclk;

    mch_setup DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .card_clk(card_clk), .cmd_bit(cmd_bit), .cmd_drive(cmd_drive),
        .cmd_sent(cmd_sent), .block_done(block_done), .data_wait(data_wait),
        .underrun_evt(underrun_evt), .overrun_evt(overrun_evt),
        .dma_done(dma_done), .cmd_desc(cmd_desc), .cmd_start(cmd_start),
        .init_active(init_active), .resp_latency(resp_latency), .xfer(xfer),
        .dma_enable(dma_enable), .dma_force_byte(dma_force_byte),
        .cmd_line_o(cmd_line_o), .cmd_line_oe(cmd_line_oe));
    mch_card_model card (.pclk(pclk), .init_active(init_active),
        .cmd_start(cmd_start), .slow(slow), .card_clk(card_clk),
        .cmd_sent(cmd_sent));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // expected command descriptor from the written word
    function automatic mch_cmd_type exp_cmd(input logic [31:0] w);
        exp_cmd = '0;
        exp_cmd.index = w[5:0];
        exp_cmd.arg = a;
        exp_cmd.special_command = w[10:8];
        exp_cmd.resp_present = w[7:6] != 2'h0;
        exp_cmd.resp_long = w[7:6] == RSP_136;
        exp_cmd.open_drain = w[11];
        exp_cmd.xfer_start = w[17:16] == TRC_START;
        exp_cmd.xfer_stop = w[17:16] == TRC_STOP;
        exp_cmd.read_dir = w[18];
        exp_cmd.transfer_type = w[21:19];
        exp_cmd.sdio_suspend = w[25:24] == IOS_SUSPEND;
        exp_cmd.sdio_resume = w[25:24] == IOS_RESUME;
    endfunction
    // one apb transfer; request held until pready is sampled
    task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) miscompares++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wait_start(input int n, output logic f);
        f = 1'b0;
        for (int k = 0; k < n && !f; k++) begin
            @(posedge pclk);
            f = (cmd_start === 1'b1);
        end
    endtask
    task wait_ready();
        for (int k = 0; k < 60; k++) begin
            apb(1'b0, OFS_SR, 32'h0);
            if (rd[SR_COMMAND_READY_FLAG] === 1'b1) break;
        end
        `CHK(rd[SR_COMMAND_READY_FLAG], 1'b1)
    endtask
    task end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge card_clk) nclk++;
    // command shifter inputs wander so the line logic sees traffic
    always @(posedge pclk) begin
        cmd_bit <= seed[3];
        cmd_drive <= seed[7];
    end
    initial begin
        repeat (30000) @(posedge pclk);
        miscompares++;
        end_sim();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata, slow, block_done} = '0;
        {data_wait, underrun_evt, overrun_evt, dma_done} = '0;
        {cmd_bit, cmd_drive, miscompares, n_tests, nclk} = '0;
        seed = 32'h270f;
        presetn = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFS_SR, 32'h0);
        `CHK(rd, 32'h1)
        apb(1'b0, 8'h1c, 32'h0);
        `CHK(err, 1'b1)
        for (int i = 0; i < 4; i++) begin
            b = rnd() & 32'hfffcffff;
            apb(1'b1, OFS_BLKR, b);
            apb(1'b0, OFS_MR, 32'h0);
            `CHK(rd, {b[31:16], 16'h0})
            `CHK({xfer.blk_len, xfer.blk_count}, b)
            c = rnd() & 32'h80;
            apb(1'b1, OFS_SDCR, c);
            apb(1'b0, OFS_SDCR, 32'h0);
            `CHK(rd, c)
            `CHK({xfer.wide_bus, xfer.slot}, {c[7], 2'h0})
        end
        b = rnd() & 32'hfffc0000;
        apb(1'b1, OFS_MR, b);
        apb(1'b0, OFS_BLKR, 32'h0);
        `CHK(rd[31:16], b[31:16])
        apb(1'b1, OFS_BLKR, b);
        $display("registers done");
        // every response, transfer and sdio code, slow and prompt card
        for (int i = 0; i < 6; i++) begin
            a = rnd();
            apb(1'b1, OFS_ARGR, a);
            c = rnd() & 32'h103f;
            c[7:6] = 2'(i % 3);
            c[11] = i[0];
            c[17:16] = 2'(i % 3);
            c[18] = i[1];
            c[21:19] = typs[i % 5];
            c[25:24] = 2'((i + 1) % 3);
            slow <= i[0];
            apb(1'b1, OFS_CMDR, c);
            wait_start(20, ok);
            `CHK(ok, 1'b1)
            `CHK(cmd_desc, exp_cmd(c))
            `CHK(resp_latency, c[12] ? LAT_LONG : LAT_SHORT)
            `CHK(xfer.blk_len, c[21:19] == 3'h4 ? 16'h0 : b[31:16])
            `CHK(xfer.unbounded, c[21:19] == TYP_MULTI)
            if (i[0]) begin
                apb(1'b1, OFS_CMDR, c ^ 32'h1);
                apb(1'b0, OFS_SR, 32'h0);
                `CHK(rd[SR_COMMAND_READY_FLAG], 1'b0)
            end
            wait_ready();
            wait_start(4, ok);
            `CHK(ok, 1'b0)
            // open drain never drives high, push pull follows the bit
            line_exp = {~c[11] & seed[3], seed[7] & ~(c[11] & seed[3])};
            `CHK({cmd_line_o, cmd_line_oe}, line_exp)
        end
        slow <= 1'b0;
        nclk = 0;
        apb(1'b1, OFS_CMDR, 32'h100);
        wait_start(1000, ok);
        `CHK(ok, 1'b1)
        `CHK(nclk, 74)
        wait_ready();
        apb(1'b1, OFS_CMDR, 32'h200);
        wait_start(20, ok);
        `CHK(ok, 1'b0)
        block_done <= 1'b1;
        @(posedge pclk);
        block_done <= 1'b0;
        wait_start(20, ok);
        `CHK(ok, 1'b1)
        wait_ready();
        apb(1'b1, OFS_CMDR, 32'h400);
        repeat (30) @(posedge pclk);
        apb(1'b1, OFS_CMDR, 32'h0);
        wait_start(20, ok);
        `CHK(ok, 1'b0)
        apb(1'b1, OFS_CMDR, 32'h500);
        wait_start(20, ok);
        `CHK(ok, 1'b1)
        wait_ready();
        $display("commands done");
        // 3 times 16 cycles of waiting for a block
        apb(1'b1, OFS_DTOR, 32'h13);
        data_wait <= 1'b1;
        repeat (27) @(posedge pclk);
        apb(1'b0, OFS_SR, 32'h0);
        `CHK(rd[SR_DATA_TIMEOUT_ERROR], 1'b0)
        repeat (30) @(posedge pclk);
        apb(1'b0, OFS_SR, 32'h0);
        `CHK(rd[SR_DATA_TIMEOUT_ERROR], 1'b1)
        data_wait <= 1'b0;
        apb(1'b1, OFS_MR, 32'ha000);
        repeat (2) @(posedge pclk);
        `CHK(dma_enable, 1'b1)
        `CHK(dma_force_byte, 1'b1)
        {underrun_evt, overrun_evt} <= 2'h3;
        @(posedge pclk);
        {underrun_evt, overrun_evt} <= 2'h0;
        apb(1'b0, OFS_SR, 32'h0);
        `CHK(rd[31:30], 2'h3)
        dma_done <= 1'b1;
        @(posedge pclk);
        dma_done <= 1'b0;
        apb(1'b0, OFS_SR, 32'h0);
        `CHK(rd[31:30], 2'h0)
        $display("timeout and dma done");
        // software reset, then a second power-on reset mid-run
        apb(1'b1, OFS_CR, 32'h80);
        apb(1'b0, OFS_MR, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b1, OFS_SDCR, 32'h80);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFS_SDCR, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b0, OFS_SR, 32'h0);
        `CHK(rd, 32'h1)
        $display("resets done");
        end_sim();
    end
endmodule
